// [verilog/cpto_map.vh]
// register map, field positions, reset values and page for the timing override bank
`ifndef CPTO_MAP_VH
`define CPTO_MAP_VH
// indirect register page that holds this bank
`define CPTO_PAGE              8'h00
// register indices (byte address = 4 * index)
`define CPTO_IDX_CLK_TRAIL     8'h42
`define CPTO_IDX_CLK_POST      8'h43
`define CPTO_IDX_HS_PREPARE    8'h44
`define CPTO_IDX_HS_ZERO       8'h45
`define CPTO_IDX_HS_TRAIL      8'h46
`define CPTO_IDX_HS_EXIT       8'h47
`define CPTO_IDX_LP_DURATION   8'h48
// number of timing registers in the bank
`define CPTO_NUM_REGS          7
// page select register index
`define CPTO_IDX_PAGE_SEL      8'h00
// field positions
`define CPTO_OVR_BIT           7
`define CPTO_VAL_MSB           6
`define CPTO_VAL_LSB           0
// reset values
`define CPTO_RST_TIMING        8'h00
`define CPTO_RST_PAGE          8'h00
`endif

// [verilog/cpto_apb_decode.v]
// apb address decode: page-qualified index to one-hot bank slot
`timescale 1ns/100ps
`include "cpto_map.vh"
module cpto_apb_decode #(
  parameter NUM_REGS = `CPTO_NUM_REGS
) (
  input  wire [11:0]         paddr,      // apb byte address
  input  wire [7:0]          page,       // current indirect page
  output wire [NUM_REGS-1:0] slot_hit,   // one-hot bank slot
  output wire                page_hit,   // page select register addressed
  output wire                mapped      // any known register
);
  wire [9:0] index;          // word index
  wire       aligned;        // low two address bits clear
  assign index   = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  // page select always visible, independent of page
  assign page_hit = aligned && (index == {2'h0, `CPTO_IDX_PAGE_SEL});
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1)
    begin : g_slot
      // consecutive indices from the trail register, page 0 only
      // compared at 32 bits so the genvar sum is never cut or padded
      assign slot_hit[g] = aligned && (page == `CPTO_PAGE) &&
                           ({22'h00_0000, index} ==
                            ({24'h00_0000, `CPTO_IDX_CLK_TRAIL} + g));
    end
  endgenerate
  assign mapped = page_hit | (|slot_hit);
endmodule // cpto_apb_decode

// [verilog/cpto_timing_field.v]
// one timing register: override bit, stored value, and value selection
`timescale 1ns/100ps
`include "cpto_map.vh"
module cpto_timing_field (
  input  wire       clock,        // system clock
  input  wire       rst_n,        // async reset, active low
  input  wire       wr_en,        // write strobe for this register
  input  wire [7:0] wr_data,      // write data byte
  input  wire [6:0] auto_value,   // automatically derived value
  output wire [7:0] read_value,   // register as software sees it
  output wire [6:0] use_value     // value the phy should use
);
  reg       override_en;          // override enable
  reg [6:0] stored_value;         // programmed value
  // override bit always writable; value writable only while override set
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      override_en  <= 1'b0;
      stored_value <= 7'h00;
    end
    else if (wr_en)
    begin
      override_en <= wr_data[`CPTO_OVR_BIT];
      // writes to the value land only when override already set
      if (override_en)
        stored_value <= wr_data[`CPTO_VAL_MSB:`CPTO_VAL_LSB];
    end
  end
  // clearing override falls straight back to the automatic value
  assign use_value  = override_en ? stored_value : auto_value;
  assign read_value = {override_en, use_value};
endmodule // cpto_timing_field

// [verilog/cpto_csi_phy_timing.v]
// csi port 0 d-phy timing override register bank, apb slave
//
// What this block does
// - clock trail: automatic unless override bit set
// - clock post: automatic unless override bit set
// - hs prepare: automatic unless override bit set
// - hs zero: automatic unless override bit set
// - hs trail: automatic unless override bit set
// - hs exit: automatic unless override bit set
// - lpx duration: automatic unless override bit set
// - value read-only showing auto unless overridden
// - bank sits in page 0 from index 0x42
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "cpto_map.vh"
module cpto_csi_phy_timing (
  input  wire        clock,                 // 200 mhz system clock
  input  wire        rst_n,                 // async reset, active low
  // apb slave
  input  wire        psel,                  // select
  input  wire        penable,               // access phase
  input  wire        pwrite,                // 1 = write
  input  wire [11:0] paddr,                 // byte address
  input  wire [31:0] pwdata,                // write data
  output reg  [31:0] prdata,                // read data
  output reg         pready,                // access done
  output reg         pslverr,               // unmapped address
  // automatic timing calculation inputs
  input  wire [6:0]  auto_clk_trail,        // derived clock trail
  input  wire [6:0]  auto_clk_post,         // derived clock post
  input  wire [6:0]  auto_hs_prepare,       // derived hs prepare
  input  wire [6:0]  auto_hs_zero,          // derived hs zero
  input  wire [6:0]  auto_hs_trail,         // derived hs trail
  input  wire [6:0]  auto_hs_exit,          // derived hs exit
  input  wire [6:0]  auto_lp_duration,      // derived lpx
  // timing in use, to the phy
  output reg  [6:0]  clk_trail_value,       // clock trail in use
  output reg  [6:0]  clk_post_value,        // clock post in use
  output reg  [6:0]  hs_prepare_value,      // hs prepare in use
  output reg  [6:0]  hs_zero_value,         // hs zero in use
  output reg  [6:0]  hs_trail_value,        // hs trail in use
  output reg  [6:0]  hs_exit_value,         // hs exit in use
  output reg  [6:0]  lp_duration_value      // lpx in use
);

////////////////////////////////////////////////////////////////////////////////
  localparam NUM = `CPTO_NUM_REGS;          // bank size

  reg  [7:0]       page;                    // indirect page select
  wire [NUM-1:0]   slot_hit;                // decoded bank slot
  wire             page_hit;                // page register addressed
  wire             mapped;                  // address known
  wire [7*NUM-1:0] auto_bus;                // packed automatic values
  wire [7*NUM-1:0] use_bus;                 // packed values in use
  wire [8*NUM-1:0] read_bus;                // packed read views
  wire             setup;                   // apb setup phase
  reg  [7:0]       next_rdata;              // selected read byte
  integer          k;                       // read mux index

  // pack auto inputs in register order
  assign auto_bus = {auto_lp_duration, auto_hs_exit, auto_hs_trail,
                     auto_hs_zero, auto_hs_prepare, auto_clk_post, auto_clk_trail};

  // answer one cycle after setup: access lasts exactly one cycle
  assign setup = psel && !penable;

////////////////////////////////////////////////////////////////////////////////
  // address decode
  cpto_apb_decode #(
    .NUM_REGS (NUM)
  ) cpto_apb_decode_i (
    .paddr    (paddr),
    .page     (page),
    .slot_hit (slot_hit),
    .page_hit (page_hit),
    .mapped   (mapped)
  );

////////////////////////////////////////////////////////////////////////////////
  // one field per timing register; write taken in access phase
  genvar g;
  generate
    for (g = 0; g < NUM; g = g + 1)
    begin : g_field
      cpto_timing_field cpto_timing_field_i (
        .clock      (clock),
        .rst_n      (rst_n),
        .wr_en      (psel && penable && pwrite && slot_hit[g]),
        .wr_data    (pwdata[7:0]),
        .auto_value (auto_bus[7*g +: 7]),
        .read_value (read_bus[8*g +: 8]),
        .use_value  (use_bus[7*g +: 7])
      );
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////////
  // read mux
  always @*
  begin
    next_rdata = 8'h00;
    if (page_hit)
      next_rdata = page;
    for (k = 0; k < NUM; k = k + 1)
      if (slot_hit[k])
        next_rdata = read_bus[8*k +: 8];
  end

  // page register and apb response
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page    <= `CPTO_RST_PAGE;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // pready high for the single access cycle after setup
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      if (psel && penable && pwrite && page_hit)
        page <= pwdata[7:0];
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // registered timing outputs to the phy
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_trail_value   <= 7'h00;
      clk_post_value    <= 7'h00;
      hs_prepare_value  <= 7'h00;
      hs_zero_value     <= 7'h00;
      hs_trail_value    <= 7'h00;
      hs_exit_value     <= 7'h00;
      lp_duration_value <= 7'h00;
    end
    else
    begin
      clk_trail_value   <= use_bus[6:0];
      clk_post_value    <= use_bus[13:7];
      hs_prepare_value  <= use_bus[20:14];
      hs_zero_value     <= use_bus[27:21];
      hs_trail_value    <= use_bus[34:28];
      hs_exit_value     <= use_bus[41:35];
      lp_duration_value <= use_bus[48:42];
    end
  end
endmodule // cpto_csi_phy_timing

// [dv/cpto_checker.sv]
// checker: apb handshake and automatic-follow rules of the timing bank
`timescale 1ns/100ps
module cpto_checker (
  input wire        clock, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [6:0]  auto_clk_trail, auto_clk_post, auto_hs_prepare, auto_hs_zero,
  input wire [6:0]  auto_hs_trail, auto_hs_exit, auto_lp_duration,
  input wire [6:0]  clk_trail_value, clk_post_value, hs_prepare_value, hs_zero_value,
  input wire [6:0]  hs_trail_value, hs_exit_value, lp_duration_value
);
  reg  [6:0]  ov;                      // override bits as software last set them
  wire [11:0] ofs = paddr - 12'h108;   // offset into the bank
  ////////////////////////////////////////////////////////////////////////
  // shadow of override bits; refused writes never reach it
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
      ov <= 7'h00;
    else if (pready && pwrite && !pslverr && paddr >= 12'h108 && paddr <= 12'h120)
      ov[ofs[4:2]] <= pwdata[7];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  // first edge after release still shows reset zeros, so the previous cycle must be live
  a_trail_auto: assert property ($past(rst_n) && !$past(ov[0])
    |-> clk_trail_value == $past(auto_clk_trail))
    else $error("clock trail not automatic");
  a_post_auto: assert property ($past(rst_n) && !$past(ov[1])
    |-> clk_post_value == $past(auto_clk_post))
    else $error("clock post not automatic");
  a_prep_auto: assert property ($past(rst_n) && !$past(ov[2])
    |-> hs_prepare_value == $past(auto_hs_prepare))
    else $error("hs prepare not automatic");
  a_zero_auto: assert property ($past(rst_n) && !$past(ov[3])
    |-> hs_zero_value == $past(auto_hs_zero))
    else $error("hs zero not automatic");
  a_hs_trail_auto: assert property ($past(rst_n) && !$past(ov[4])
    |-> hs_trail_value == $past(auto_hs_trail))
    else $error("hs trail not automatic");
  a_exit_auto: assert property ($past(rst_n) && !$past(ov[5])
    |-> hs_exit_value == $past(auto_hs_exit))
    else $error("hs exit not automatic");
  a_lpx_auto: assert property ($past(rst_n) && !$past(ov[6])
    |-> lp_duration_value == $past(auto_lp_duration))
    else $error("lpx not automatic");
endmodule // cpto_checker
bind cpto_csi_phy_timing cpto_checker cpto_checker_i (.*);

// [dv/cpto_csi_phy_timing_tb.sv]
// testbench: apb register tests of the timing override bank
`timescale 1ns/100ps
module cpto_csi_phy_timing_tb;
  reg        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
  reg [11:0] paddr = 12'h000, a;
  reg [31:0] pwdata = 32'h0, rd;
  reg [6:0]  au [0:6], v;            // automatic inputs, override value
  wire [6:0] vo [0:6];               // values in use
  wire [31:0] prdata;
  wire       pready, pslverr;
  int        mismatches = 0, n_tests = 0, cyc = 0, i;
  cpto_csi_phy_timing cpto_csi_phy_timing_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .auto_clk_trail(au[0]), .auto_clk_post(au[1]),
    .auto_hs_prepare(au[2]), .auto_hs_zero(au[3]), .auto_hs_trail(au[4]),
    .auto_hs_exit(au[5]), .auto_lp_duration(au[6]), .clk_trail_value(vo[0]),
    .clk_post_value(vo[1]), .hs_prepare_value(vo[2]), .hs_zero_value(vo[3]),
    .hs_trail_value(vo[4]), .hs_exit_value(vo[5]), .lp_duration_value(vo[6]));
  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  // timeout: the tests take well under a thousand cycles
  always @(posedge clock)
    if (++cyc > 5000)
    begin
      mismatches++;
      tally_and_finish;
    end
  task chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; waits on pready, bounded by the timeout
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence: every register through auto, override and back
  initial
  begin
    for (i = 0; i < 7; i++) au[i] = 7'h11 + 7'(3 * i);
    repeat (20) @(posedge clock);
    rst_n <= 1;
    for (i = 0; i < 7; i++)
    begin
      a = 12'h108 + 12'(4 * i);
      v = 7'h60 - 7'(i);
      apb(1, a, 32'h7F);                  // value write ignored, override clear
      apb(0, a, 0);
      chk("auto read", rd, {25'h0, au[i]});
      chk("auto use", vo[i], au[i]);
      apb(1, a, 32'h80);
      apb(0, a, 0);
      chk("ovr kept", rd, 32'h80);
      apb(1, a, {24'h0, 1'b1, v});
      apb(0, a, 0);
      chk("ovr read", rd, {24'h0, 1'b1, v});
      au[i] <= au[i] + 7'h01;              // auto moves, override holds
      repeat (2) @(posedge clock);
      chk("ovr use", vo[i], v);
      apb(1, a, 32'h00);
      apb(0, a, 0);
      chk("back read", rd, {25'h0, au[i]});
      chk("back use", vo[i], au[i]);
    end
    // refusals: unmapped, unaligned, other page
    apb(0, 12'h124, 0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    apb(0, 12'h109, 0);
    chk("unaligned", er, 1'b1);
    apb(1, 12'h000, 32'h01);
    apb(0, 12'h108, 0);
    chk("page one", er, 1'b1);
    apb(1, 12'h000, 32'h00);
    apb(0, 12'h108, 0);
    chk("page zero", er, 1'b0);
    // mid-run reset drops an override back to the automatic value
    apb(1, 12'h108, 32'h80);
    rst_n <= 0;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    apb(0, 12'h108, 0);
    chk("reset read", rd, {25'h0, au[0]});
    tally_and_finish;
  end
endmodule // cpto_csi_phy_timing_tb
